// ===== hdl/imcmd_defs.svh
`ifndef IMCMD_DEFS_SVH
`define IMCMD_DEFS_SVH
// Command codes in byte 0 of an immediate command.
`define IMCMD_OP_ROUTE 8'h47
`define IMCMD_OP_CLRCFG 8'h48
`define IMCMD_OP_LDPARM 8'h49
`define IMCMD_OP_MOVVEL 8'h22
`define IMCMD_OP_MOVE 8'h23
`define IMCMD_OP_FRCVEL 8'h24
`define IMCMD_OP_FRCAOUT 8'h25
`define IMCMD_OP_POSINC 8'h26
`define IMCMD_OP_STOP 8'h27
// Connector codes.
`define IMCMD_CON_A 8'h01
`define IMCMD_CON_B 8'h02
`define IMCMD_CON_C 8'h03
`define IMCMD_CON_D 8'h04
// Signal codes, decimal as the host writes them.
`define IMCMD_SIG_FORCED 16'h0000
`define IMCMD_SIG_TRQ1 16'h000A
`define IMCMD_SIG_VEL1 16'h000F
`define IMCMD_SIG_TRQ2 16'h0014
`define IMCMD_SIG_VEL2 16'h0019
`endif

// ===== hdl/imcmd_pkg.sv
package imcmd_pkg;
  // Source placed on one analog output connector.
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_FORCED,
    SRC_TRQ1,
    SRC_VEL1,
    SRC_TRQ2,
    SRC_VEL2
  } imcmd_src_e;
  // One six-byte immediate command.
  typedef struct packed {
    logic [15:0] word2;
    logic [15:0] sig_code;
    logic [7:0] arg;
    logic [7:0] opcode;
  } imcmd_cmd_s;
  // Acceleration choice for the motion generator.
  typedef struct packed {
    logic use_jog;
    logic use_prog;
  } imcmd_accel_s;
endpackage

// ===== hdl/imcmd_handler.sv
`include "imcmd_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module imcmd_handler #(
  parameter int AXES = 4,
  parameter int PARMS = 256,
  parameter logic [1:0] FORCED_HOME = 2'd3
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Per-axis immediate command words, sampled on the sweep strobe.
  input wire logic sweep_in,
  input wire imcmd_pkg::imcmd_cmd_s [3:0] cmd_in,
  input wire logic [31:0] parm_data_in,
  input wire logic reconfig_in,
  input wire logic digital_servo_in,
  // Discrete motion request bits and the parameter read index.
  input wire logic jog_in,
  input wire logic home_in,
  input wire logic prog_start_in,
  input wire logic motion_done_in,
  input wire logic pause_in,
  input wire logic [7:0] parm_rd_idx_in,
  // Status and routing outputs.
  output logic cfg_recv_out,
  output imcmd_pkg::imcmd_src_e [3:0] con_src_out,
  output logic motion_err_out,
  output logic posinc_out,
  output logic [2:0] motion_start_out,
  output imcmd_pkg::imcmd_accel_s accel_out,
  output logic [31:0] parm_rd_out
);
  initial begin
    if (AXES < 1 || AXES > 4 || PARMS != 256) $error("imcmd_handler: bad parameters");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command decode, every axis word group in parallel.
  function automatic logic is_op(imcmd_pkg::imcmd_cmd_s c, logic [7:0] op);
    return c.opcode == op;
  endfunction
  function automatic logic con_ok(logic [7:0] c);
    return c >= `IMCMD_CON_A && c <= `IMCMD_CON_D;
  endfunction
  function automatic imcmd_pkg::imcmd_src_e sig_map(logic [15:0] s);
    case (s)
      `IMCMD_SIG_FORCED: return imcmd_pkg::SRC_FORCED;
      `IMCMD_SIG_TRQ1: return imcmd_pkg::SRC_TRQ1;
      `IMCMD_SIG_VEL1: return imcmd_pkg::SRC_VEL1;
      `IMCMD_SIG_TRQ2: return imcmd_pkg::SRC_TRQ2;
      `IMCMD_SIG_VEL2: return imcmd_pkg::SRC_VEL2;
      default: return imcmd_pkg::SRC_NONE;
    endcase
  endfunction
  logic [3:0] route_v, clr_v, load_v, move_v, posinc_v;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dec
      wire logic live = sweep_in && (g < AXES);
      assign route_v[g] = live && is_op(cmd_in[g], `IMCMD_OP_ROUTE)
                          && con_ok(cmd_in[g].arg)
                          && sig_map(cmd_in[g].sig_code) != imcmd_pkg::SRC_NONE;
      assign clr_v[g] = live && is_op(cmd_in[g], `IMCMD_OP_CLRCFG);
      assign load_v[g] = live && is_op(cmd_in[g], `IMCMD_OP_LDPARM);
      assign move_v[g] = live && (is_op(cmd_in[g], `IMCMD_OP_MOVVEL)
                         || is_op(cmd_in[g], `IMCMD_OP_MOVE)
                         || is_op(cmd_in[g], `IMCMD_OP_FRCVEL));
      assign posinc_v[g] = live && is_op(cmd_in[g], `IMCMD_OP_POSINC);
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // Analog output routing; a later axis word wins within one sweep.
  imcmd_pkg::imcmd_src_e [3:0] con_r, con_nxt;
  always_comb begin
    con_nxt = con_r;
    for (int i = 0; i < 4; i++) begin
      if (route_v[i] && !digital_servo_in) begin
        if (sig_map(cmd_in[i].sig_code) == imcmd_pkg::SRC_FORCED) begin
          // Forced value only returns to its home connector.
          // The connector code is already known to be 01h-04h, so two bits name it.
          if (2'(cmd_in[i].arg - 8'd1) == FORCED_HOME)
            con_nxt[FORCED_HOME] = imcmd_pkg::SRC_FORCED;
        end else begin
          con_nxt[2'(cmd_in[i].arg - 8'd1)] = sig_map(cmd_in[i].sig_code);
        end
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || reconfig_in) begin
      con_r <= '{default: imcmd_pkg::SRC_NONE};
      con_r[0] <= imcmd_pkg::SRC_VEL1;
      con_r[1] <= imcmd_pkg::SRC_VEL2;
      con_r[FORCED_HOME] <= imcmd_pkg::SRC_FORCED;
    end else begin
      con_r <= con_nxt;
    end
  end
  assign con_src_out = con_r;
  ////////////////////////////////////////////////////////////////////////////
  // Configuration-received flag; reconfiguration outranks a clear.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || reconfig_in)
      cfg_recv_out <= 1'b1;
    else if (|clr_v)
      cfg_recv_out <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Parameter store, read only by the program executor port.
  logic [31:0] parm_r [PARMS];
  always_ff @(posedge clk_sys_in) begin
    for (int i = 0; i < 4; i++) begin
      if (load_v[i])
        parm_r[cmd_in[i].arg] <= parm_data_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in)
      parm_rd_out <= 32'h0;
    else
      parm_rd_out <= parm_r[parm_rd_idx_in];
  end
  ////////////////////////////////////////////////////////////////////////////
  // Motion exclusion: one exclusive motion at a time.
  typedef enum logic [1:0] {ST_IDLE, ST_EXCL, ST_PROG} imcmd_mst_e;
  imcmd_mst_e mst_r;
  wire logic any_req = (|move_v) || jog_in || home_in || prog_start_in;
  wire logic imm_req = (|move_v) || jog_in || home_in;
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mst_r <= ST_IDLE;
      motion_err_out <= 1'b0;
      motion_start_out <= 3'h0;
      posinc_out <= 1'b0;
      accel_out <= '0;
    end else begin
      posinc_out <= |posinc_v;
      motion_start_out <= 3'h0;
      motion_err_out <= 1'b0;
      case (mst_r)
        ST_IDLE: begin
          if (imm_req) begin
            mst_r <= ST_EXCL;
            motion_start_out <= {|move_v, home_in, jog_in};
            accel_out <= '{use_jog: 1'b1, use_prog: 1'b0};
          end else if (prog_start_in) begin
            mst_r <= ST_PROG;
            accel_out <= '{use_jog: 1'b0, use_prog: 1'b1};
          end
        end
        ST_EXCL: begin
          if (any_req) motion_err_out <= 1'b1;
          // A pause always ramps at the programmed rate, whatever motion runs.
          if (pause_in) accel_out <= '{use_jog: 1'b0, use_prog: 1'b1};
          if (motion_done_in) mst_r <= ST_IDLE;
        end
        ST_PROG: begin
          if (pause_in) accel_out <= '{use_jog: 1'b0, use_prog: 1'b1};
          if (motion_done_in) mst_r <= ST_IDLE;
        end
        default: mst_r <= ST_IDLE;
      endcase
    end
  end
endmodule // imcmd_handler
`default_nettype wire

// ===== verification/imcmd_plc.sv
`timescale 1ns/1ns
`default_nettype none
module imcmd_plc (
  // Clock and staged words.
  input wire logic clk_sys_in,
  input wire logic go_in,
  input wire imcmd_pkg::imcmd_cmd_s [3:0] words_in,
  // Sweep toward the module.
  output logic sweep_out = 1'b0,
  output imcmd_pkg::imcmd_cmd_s [3:0] cmd_out = '0
);
  imcmd_pkg::imcmd_cmd_s w;
  // Words toggle between sweeps, so nothing may lean on them there.
  always @(posedge clk_sys_in) begin
    sweep_out <= go_in;
    for (int i = 0; i < 4; i++) begin // One load per word at most.
      w = words_in[i];
      w.word2 = 16'h0000;
      cmd_out[i] <= go_in ? w : ~cmd_out[i];
    end
  end
endmodule // imcmd_plc
`default_nettype wire

// ===== verification/imcmd_handler_chk.sv
`timescale 1ns/1ns
`default_nettype none
module imcmd_handler_chk (
  // Watched ports.
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic sweep_in,
  input wire logic reconfig_in,
  input wire logic digital_servo_in,
  input wire imcmd_pkg::imcmd_cmd_s [3:0] cmd_in,
  input wire logic cfg_recv_out,
  input wire imcmd_pkg::imcmd_src_e [3:0] con_src_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // The last word wins, so only it is judged; q means no other word routes.
  wire go = sweep_in && !reconfig_in && !digital_servo_in && cmd_in[3].opcode == 8'h47;
  wire q = cmd_in[0].opcode != 8'h47 && cmd_in[1].opcode != 8'h47 && cmd_in[2].opcode != 8'h47;
  wire [15:0] s = cmd_in[3].sig_code;
  wire [7:0] c = cmd_in[3].arg;
  wire ok = c inside {[8'h01:8'h04]};
  wire [1:0] k = c[1:0] - 2'h1;
  wire cl = sweep_in && !reconfig_in && (cmd_in[0].opcode == 8'h48 ||
    cmd_in[1].opcode == 8'h48 || cmd_in[2].opcode == 8'h48 || cmd_in[3].opcode == 8'h48);
  ////////////////////////////////////////
  vel1_route_a: assert property (go && ok && s == 16'h000F |=>
    con_src_out[$past(k)] == imcmd_pkg::SRC_VEL1) else $error("vel1 not routed");
  trq1_route_a: assert property (go && ok && s == 16'h000A |=>
    con_src_out[$past(k)] == imcmd_pkg::SRC_TRQ1) else $error("trq1 not routed");
  trq2_route_a: assert property (go && ok && s == 16'h0014 |=>
    con_src_out[$past(k)] == imcmd_pkg::SRC_TRQ2) else $error("trq2 not routed");
  forced_home_a: assert property (go && s == 16'h0000 && c == 8'h04 |=>
    con_src_out[3] == imcmd_pkg::SRC_FORCED) else $error("forced not restored");
  bad_route_a: assert property (go && q && (!ok || s == 16'h000B || s == 16'h0000 && c != 8'h04)
    |=> $stable(con_src_out)) else $error("refused route applied");
  digital_hold_a: assert property (sweep_in && digital_servo_in && !reconfig_in
    |=> $stable(con_src_out)) else $error("routing moved in digital mode");
  cfg_clear_a: assert property (cl |=> !cfg_recv_out) else $error("flag not cleared");
  cfg_set_a: assert property (!cfg_recv_out ##1 cfg_recv_out |-> $past(reconfig_in))
    else $error("flag set without reconfig");
  cover property (go && ok && s == 16'h000A);
  cover property (sweep_in && digital_servo_in);
  cover property (cl);
endmodule // imcmd_handler_chk
`default_nettype wire

// ===== verification/imcmd_handler_test.sv
`timescale 1ns/1ns
`default_nettype none
module imcmd_handler_test;
  localparam imcmd_pkg::imcmd_src_e N = imcmd_pkg::SRC_NONE, F = imcmd_pkg::SRC_FORCED,
    T1 = imcmd_pkg::SRC_TRQ1, V1 = imcmd_pkg::SRC_VEL1, T2 = imcmd_pkg::SRC_TRQ2,
    V2 = imcmd_pkg::SRC_VEL2;
  logic clk_sys_in = 0, rstn_in = 0, go = 0, rcf = 0, dig = 0, jog = 0, home = 0, pz = 0, dn = 0;
  logic ps = 0;
  logic sweep, cfg, err, pinc;
  logic [2:0] mst;
  logic [31:0] pd = 0, prd;
  logic [7:0] pidx = 0;
  imcmd_pkg::imcmd_cmd_s [3:0] wd = '0, cmd;
  imcmd_pkg::imcmd_src_e [3:0] con;
  imcmd_pkg::imcmd_accel_s acc;
  int miscompares = 0, checks = 0;
  logic [7:0] rc [8] = '{8'h02, 8'h04, 8'h03, 8'h01, 8'h01, 8'h04, 8'h05, 8'h02};
  logic [15:0] rs [8] = '{16'h000F, 16'h000A, 16'h0014, 16'h0019, 16'h0000, 16'h0000,
    16'h000F, 16'h000B};
  logic [11:0] re [8] = '{{F, N, V1, V1}, {T1, N, V1, V1}, {T1, T2, V1, V1}, {T1, T2, V1, V2},
    {T1, T2, V1, V2}, {F, T2, V1, V2}, {F, T2, V1, V2}, {F, T2, V1, V2}};
  logic [7:0] ix [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
  imcmd_plc u_imcmd_plc (.clk_sys_in, .go_in(go), .words_in(wd), .sweep_out(sweep), .cmd_out(cmd));
  imcmd_handler u_imcmd_handler (.clk_sys_in, .rstn_in, .sweep_in(sweep), .cmd_in(cmd),
    .parm_data_in(pd), .reconfig_in(rcf), .digital_servo_in(dig), .jog_in(jog), .home_in(home),
    .prog_start_in(ps), .motion_done_in(dn), .pause_in(pz), .parm_rd_idx_in(pidx),
    .cfg_recv_out(cfg), .con_src_out(con), .motion_err_out(err), .posinc_out(pinc),
    .motion_start_out(mst), .accel_out(acc), .parm_rd_out(prd));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////
  // Compare and count.
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One sweep with a word on axis a; returns just after the answer edge.
  task send(input logic [1:0] a, input logic [7:0] op, arg, input logic [15:0] sg);
    imcmd_pkg::imcmd_cmd_s [3:0] t;
    t = '0;
    t[a] = {16'h0000, sg, arg, op};
    @(posedge clk_sys_in) wd <= t;
    go <= 1'b1;
    @(posedge clk_sys_in) go <= 1'b0;
    @(posedge clk_sys_in) #1;
  endtask
  // One-cycle pulse on {reconfig, jog, home, pause, done}.
  task pul(input logic [4:0] m);
    @(posedge clk_sys_in) {rcf, jog, home, pz, dn} <= m;
    @(posedge clk_sys_in) {rcf, jog, home, pz, dn} <= 5'h00;
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    #1 chk(con, {F, N, V2, V1});
    for (int i = 0; i < 8; i++) begin
      send(2'h3, 8'h47, rc[i], rs[i]);
      chk(con, re[i]);
    end
    @(posedge clk_sys_in) dig <= 1'b1;
    send(2'h3, 8'h47, 8'h01, 16'h000A);
    chk(con, {F, T2, V1, V2});
    dig <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      pul(5'h10);
      chk({cfg, con}, {1'b1, F, N, V2, V1});
      send(a[1:0], 8'h48, 8'h00, 16'h0000);
      chk(cfg, 0);
    end
    for (int a = 0; a < 4; a++) begin
      @(posedge clk_sys_in) pd <= {24'hA5C300, ix[a]};
      send(a[1:0], 8'h49, ix[a], 16'h0000);
    end
    for (int a = 0; a < 4; a++) begin
      @(posedge clk_sys_in) pidx <= ix[a];
      @(posedge clk_sys_in) #1 chk(prd, {24'hA5C300, ix[a]});
    end
    pul(5'h08);
    chk({mst, acc}, {3'h1, 2'h2});
    pul(5'h04);
    chk(err, 1);
    send(2'h0, 8'h26, 8'h00, 16'h0000);
    chk({pinc, err}, 2'h2);
    pul(5'h02);
    chk(acc, 2'h1);
    @(posedge clk_sys_in) ps <= 1'b1;
    @(posedge clk_sys_in) ps <= 1'b0;
    #1 chk(err, 1);
    pul(5'h01);
    results;
  end
endmodule // imcmd_handler_test
bind imcmd_handler imcmd_handler_chk u_imcmd_handler_chk (.clk_sys_in, .rstn_in, .sweep_in,
  .reconfig_in, .digital_servo_in, .cmd_in, .cfg_recv_out, .con_src_out);
`default_nettype wire
